/* File: inc/pin_float_pkg.sv */
package pin_float_pkg;

  // register byte offsets on the AHB-Lite slave
  localparam logic [7:0] instr_off = 8'h00;
  localparam logic [7:0] operand_reg_off = 8'h04;
  localparam logic [7:0] range_setup_prefix_off = 8'h08;
  localparam logic [7:0] operand_augment_prefix_off = 8'h0C;
  localparam logic [7:0] flags_off = 8'h10;
  localparam logic [7:0] lower_port_direction_reg_off = 8'h14;
  localparam logic [7:0] upper_port_direction_reg_off = 8'h18;
  localparam logic [7:0] lower_port_output_reg_off = 8'h1C;
  localparam logic [7:0] upper_port_output_reg_off = 8'h20;
  localparam logic [7:0] status_off = 8'h24;
  localparam logic [7:0] last_off = 8'h24;

  // instruction word layout
  localparam int opcode_hi = 27;
  localparam int opcode_lo = 21;
  localparam int fx_c_bit = 20;
  localparam int fx_z_bit = 19;
  localparam int fx_lit_bit = 18;
  localparam int dest_hi = 17;
  localparam int dest_lo = 9;
  localparam int src_hi = 8;
  localparam int src_lo = 0;

  localparam logic [6:0] pin_op_opcode = 7'h6B;
  localparam logic [8:0] float_low_src = 9'h050;
  localparam logic [8:0] float_high_src = 9'h051;
  localparam logic [8:0] float_to_carry_src = 9'h052;
  localparam logic [8:0] float_to_not_carry_src = 9'h053;

  // pin range value layout
  localparam int base_hi = 5;
  localparam int base_lo = 0;
  localparam int range_hi = 10;
  localparam int range_lo = 6;
  localparam int port_sel_bit = 5;

  // flag and status bit positions
  localparam int flag_c_bit = 0;
  localparam int flag_z_bit = 1;
  localparam int status_busy_bit = 0;
  localparam int status_illegal_bit = 1;

  // reset values
  localparam logic [31:0] port_reset = 32'h0000_0000;
  localparam logic [31:0] word_reset = 32'h0000_0000;

  localparam logic [1:0] htrans_nonseq = 2'h2;
  localparam logic hresp_okay = 1'b0;

  typedef enum logic [1:0] {
    level_low = 2'b00,
    level_high = 2'b01,
    level_carry = 2'b10,
    level_not_carry = 2'b11
  } level_kind_t;

  typedef enum logic [1:0] {
    fsm_idle = 2'b00,
    fsm_decode = 2'b01,
    fsm_commit = 2'b10
  } fsm_t;

  typedef struct packed {
    logic dp_valid;
    logic dp_write;
    logic [7:0] dp_addr;
    logic rd_done;
    logic [31:0] rdata;
    logic [31:0] instr;
    logic [31:0] operand_reg;
    logic [4:0] prefix;
    logic prefix_pend;
    logic [1:0] augment;
    logic augment_pend;
    logic carry;
    logic zero;
    logic [31:0] lower_port_direction_reg;
    logic [31:0] upper_port_direction_reg;
    logic [31:0] lower_port_output_reg;
    logic [31:0] upper_port_output_reg;
    logic illegal;
    fsm_t fsm;
    level_kind_t ex_kind;
    logic ex_write_both_flags;
    logic ex_port;
    logic [31:0] ex_mask;
    logic ex_old_base;
  } state_t;

endpackage

/* File: rtl/pin_float_instruction_unit.sv */
`timescale 1ns/1ps
// Behaviour
// R01: float_to_carry loads C; not-carry loads inverted C
// R02: float_high latches 1, float_low latches 0
// R03: unselected pins keep direction and output
// R04: write both direction and output registers
// R05: operand bits 5:0 give base pin
// R06: operand bits 10:6 give extra pins
// R07: 9-bit literal; augment prefix extends to 11
// R08: register operand low 11 bits used directly
// R09: range prefix replaces bits 10:6; code does this for register operands only, literals ignore it
// R10: range wraps within one 32-pin port
// R11: write_both_flags loads old base output bit
// R12: only combined carry-zero flag effect accepted
// R13: new direction not forwarded to next instruction
// R14: software waits two instructions before touching direction
// R15: carry variants decode opcode 1101011, sources 52/53
// R16: high/low variants decode sources 51/50
// R17: every float instruction takes two clocks
// R18: no flag effect leaves flags unchanged
// R19: base bit 5 selects lower or upper port
// R20: zero range affects only base pin
module pin_float_instruction_unit (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic [63:0] pin_dir,
  output logic [63:0] pin_out
);

  pin_float_pkg::state_t state;
  pin_float_pkg::state_t next_state;

  // selection mask for a base pin and a count of extra pins, wrapping in 32
  function automatic logic [31:0] range_mask(input logic [4:0] base, input logic [4:0] extra);
    logic [31:0] m;
    logic [4:0] off;
    m = 32'h0000_0000;
    for (int i = 0; i < 32; i++) begin
      off = 5'(i) - base; // R10
      m[i] = (off <= extra); // R06 R20
    end
    return m;
  endfunction

  logic busy;
  logic wr_go;
  logic rd_go;
  logic [31:0] rd_mux;
  logic [10:0] lit_val;
  logic [10:0] pin_val;
  logic [8:0] op_src;
  logic fx_c;
  logic fx_z;
  logic [31:0] base_word;
  logic [31:0] sel_out;
  logic [31:0] sel_dir;
  logic level;

  assign busy = (state.fsm != pin_float_pkg::fsm_idle);
  // writes wait while an instruction is in flight, reads take one wait state
  assign wr_go = state.dp_valid && state.dp_write && !busy;
  assign rd_go = state.dp_valid && !state.dp_write && !state.rd_done;
  assign hreadyout = !(state.dp_valid && (state.dp_write ? busy : !state.rd_done));
  assign hrdata = state.rdata;
  assign hresp = pin_float_pkg::hresp_okay;
  assign pin_dir = {state.upper_port_direction_reg, state.lower_port_direction_reg};
  assign pin_out = {state.upper_port_output_reg, state.lower_port_output_reg};

  // output word of the port that holds the base pin
  assign base_word = pin_val[pin_float_pkg::port_sel_bit] ? state.upper_port_output_reg :
                     state.lower_port_output_reg; // R19
  assign op_src = state.instr[pin_float_pkg::src_hi:pin_float_pkg::src_lo];
  assign fx_c = state.instr[pin_float_pkg::fx_c_bit];
  assign fx_z = state.instr[pin_float_pkg::fx_z_bit];

  always_comb begin
    // literal: 11 bits, top two from the augment prefix when one is pending
    lit_val = {state.augment_pend ? state.augment : 2'b00,
               state.instr[pin_float_pkg::dest_hi:pin_float_pkg::dest_lo]}; // R07
    if (state.instr[pin_float_pkg::fx_lit_bit]) begin
      pin_val = lit_val;
    end else begin
      pin_val = state.operand_reg[10:0]; // R08
      if (state.prefix_pend) begin
        pin_val[pin_float_pkg::range_hi:pin_float_pkg::range_lo] = state.prefix; // R09
      end
    end
  end

  // legality check on the word being written
  function automatic logic legal_word(input logic [31:0] w);
    logic [6:0] c;
    logic [8:0] s;
    c = w[pin_float_pkg::opcode_hi:pin_float_pkg::opcode_lo];
    s = w[pin_float_pkg::src_hi:pin_float_pkg::src_lo];
    return (c == pin_float_pkg::pin_op_opcode) && // R15
           ((s == pin_float_pkg::float_to_carry_src) ||
            (s == pin_float_pkg::float_to_not_carry_src) || // R15
            (s == pin_float_pkg::float_high_src) ||
            (s == pin_float_pkg::float_low_src)) && // R16
           (w[pin_float_pkg::fx_c_bit] == w[pin_float_pkg::fx_z_bit]); // R12
  endfunction

  always_comb begin
    sel_out = state.ex_port ? state.upper_port_output_reg : state.lower_port_output_reg;
    sel_dir = state.ex_port ? state.upper_port_direction_reg : state.lower_port_direction_reg;
    unique case (state.ex_kind)
      pin_float_pkg::level_low: level = 1'b0; // R02
      pin_float_pkg::level_high: level = 1'b1; // R02
      pin_float_pkg::level_carry: level = state.carry; // R01
      pin_float_pkg::level_not_carry: level = !state.carry; // R01
    endcase
  end

  always_comb begin
    unique case (state.dp_addr)
      pin_float_pkg::instr_off: rd_mux = state.instr;
      pin_float_pkg::operand_reg_off: rd_mux = state.operand_reg;
      pin_float_pkg::range_setup_prefix_off: rd_mux = {27'h0, state.prefix};
      pin_float_pkg::operand_augment_prefix_off: rd_mux = {30'h0, state.augment};
      pin_float_pkg::flags_off: rd_mux = {30'h0, state.zero, state.carry};
      pin_float_pkg::lower_port_direction_reg_off: rd_mux = state.lower_port_direction_reg;
      pin_float_pkg::upper_port_direction_reg_off: rd_mux = state.upper_port_direction_reg;
      pin_float_pkg::lower_port_output_reg_off: rd_mux = state.lower_port_output_reg;
      pin_float_pkg::upper_port_output_reg_off: rd_mux = state.upper_port_output_reg;
      pin_float_pkg::status_off: rd_mux = {30'h0, state.illegal, busy};
      default: rd_mux = pin_float_pkg::word_reset;
    endcase
  end

  always_comb begin
    next_state = state;

    // data phase bookkeeping
    if (rd_go) begin
      next_state.rdata = rd_mux; // R13
      next_state.rd_done = 1'b1;
    end
    if (hreadyout) begin
      next_state.dp_valid = 1'b0;
      next_state.rd_done = 1'b0;
      if (hsel && hready && (htrans == pin_float_pkg::htrans_nonseq)) begin
        next_state.dp_valid = 1'b1;
        next_state.dp_write = hwrite;
        next_state.dp_addr = {haddr[7:2], 2'b00};
      end
    end

    // instruction pipeline, two clocks from issue to commit
    unique case (state.fsm)
      pin_float_pkg::fsm_idle: begin
      end
      pin_float_pkg::fsm_decode: begin
        next_state.fsm = pin_float_pkg::fsm_commit; // R17
        next_state.ex_kind = pin_float_pkg::level_kind_t'(op_src[1:0]);
        next_state.ex_write_both_flags = fx_c && fx_z;
        next_state.ex_port = pin_val[pin_float_pkg::port_sel_bit]; // R19
        next_state.ex_mask = range_mask(pin_val[4:0],
                                        pin_val[pin_float_pkg::range_hi:pin_float_pkg::range_lo]);
        next_state.ex_old_base = base_word[pin_val[4:0]]; // R05
        next_state.prefix_pend = 1'b0;
        next_state.augment_pend = 1'b0;
      end
      pin_float_pkg::fsm_commit: begin
        next_state.fsm = pin_float_pkg::fsm_idle; // R17
        // direction cleared, then level applied, only inside the mask
        if (state.ex_port) begin
          next_state.upper_port_direction_reg = sel_dir & ~state.ex_mask; // R04 R03
          next_state.upper_port_output_reg = (sel_out & ~state.ex_mask) |
                                             (state.ex_mask & {32{level}}); // R04 R03
        end else begin
          next_state.lower_port_direction_reg = sel_dir & ~state.ex_mask; // R04 R03
          next_state.lower_port_output_reg = (sel_out & ~state.ex_mask) |
                                             (state.ex_mask & {32{level}}); // R04 R03
        end
        if (state.ex_write_both_flags) begin
          next_state.carry = state.ex_old_base; // R11
          next_state.zero = state.ex_old_base; // R11
        end // R18
      end
      default: next_state.fsm = pin_float_pkg::fsm_idle;
    endcase

    // register writes; only taken while no instruction is in flight
    if (wr_go) begin
      unique case (state.dp_addr)
        pin_float_pkg::instr_off: begin
          next_state.instr = hwdata;
          if (legal_word(hwdata)) begin
            next_state.fsm = pin_float_pkg::fsm_decode;
            next_state.illegal = 1'b0;
          end else begin
            next_state.illegal = 1'b1;
            next_state.prefix_pend = 1'b0;
            next_state.augment_pend = 1'b0;
          end
        end
        pin_float_pkg::operand_reg_off: next_state.operand_reg = hwdata;
        pin_float_pkg::range_setup_prefix_off: begin
          next_state.prefix = hwdata[4:0];
          next_state.prefix_pend = 1'b1;
        end
        pin_float_pkg::operand_augment_prefix_off: begin
          next_state.augment = hwdata[1:0];
          next_state.augment_pend = 1'b1;
        end
        pin_float_pkg::flags_off: begin
          next_state.carry = hwdata[pin_float_pkg::flag_c_bit];
          next_state.zero = hwdata[pin_float_pkg::flag_z_bit];
        end
        pin_float_pkg::lower_port_direction_reg_off: next_state.lower_port_direction_reg = hwdata;
        pin_float_pkg::upper_port_direction_reg_off: next_state.upper_port_direction_reg = hwdata;
        pin_float_pkg::lower_port_output_reg_off: next_state.lower_port_output_reg = hwdata;
        pin_float_pkg::upper_port_output_reg_off: next_state.upper_port_output_reg = hwdata;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= '{
        dp_valid: 1'b0,
        dp_write: 1'b0,
        dp_addr: 8'h00,
        rd_done: 1'b0,
        rdata: pin_float_pkg::word_reset,
        instr: pin_float_pkg::word_reset,
        operand_reg: pin_float_pkg::word_reset,
        prefix: 5'h00,
        prefix_pend: 1'b0,
        augment: 2'h0,
        augment_pend: 1'b0,
        carry: 1'b0,
        zero: 1'b0,
        lower_port_direction_reg: pin_float_pkg::port_reset,
        upper_port_direction_reg: pin_float_pkg::port_reset,
        lower_port_output_reg: pin_float_pkg::port_reset,
        upper_port_output_reg: pin_float_pkg::port_reset,
        illegal: 1'b0,
        fsm: pin_float_pkg::fsm_idle,
        ex_kind: pin_float_pkg::level_low,
        ex_write_both_flags: 1'b0,
        ex_port: 1'b0,
        ex_mask: 32'h0000_0000,
        ex_old_base: 1'b0
      };
    end else begin
      state <= next_state;
    end
  end

endmodule

/* File: verification/pin_float_chk.sv */
`timescale 1ns/1ps
module pin_float_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [63:0] pin_dir,
  input wire logic [63:0] pin_out
);
  logic dv, dw, ag;
  logic [5:0] da, bq;
  logic [1:0] aq, kq;
  logic [63:0] mq;
  function automatic logic [63:0] msk(logic [5:0] b, logic [4:0] r);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 32; i++) if (i <= r) m[5'(b[4:0] + i)] = 1'b1;
    return b[5] ? {m, 32'h0} : {32'h0, m};
  endfunction
  wire done = dv && hreadyout;
  wire ins = done && dw && da == 6'h00;
  wire ok = hwdata[27:21] == 7'h6B && hwdata[8:2] == 7'h14 && hwdata[20] == hwdata[19];
  wire go = ins && ok && hwdata[18];
  wire bad = ins && !ok;
  wire pw = done && dw && (da == 6'h05 || da == 6'h06);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dv <= 1'b0;
      ag <= 1'b0;
    end else begin
      if (hready) dv <= hsel && htrans == 2'h2;
      if (hready) dw <= hwrite;
      if (hready) da <= haddr[7:2];
      if (done && dw && da == 6'h03) aq <= hwdata[1:0];
      ag <= ins ? 1'b0 : (done && dw && da == 6'h03) ? 1'b1 : ag;
      if (go) bq <= hwdata[14:9];
      if (go) kq <= hwdata[1:0];
      if (go) mq <= msk(hwdata[14:9], {ag ? aq : 2'h0, hwdata[17:15]});
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_OLD_HELD: assert property (go |=> $stable({pin_dir, pin_out})[*2])
    else $error("pins changed before commit");
  AST_BASE: assert property (go |-> ##3 !pin_dir[bq])
    else $error("base pin not floated");
  AST_CLEAR: assert property (go |-> ##3 (pin_dir & mq) == 64'h0)
    else $error("selected pin still output");
  AST_LEVEL: assert property (go && !hwdata[1] |-> ##3 (pin_out & mq) == (mq & {64{kq[0]}}))
    else $error("fixed level wrong");
  AST_KEEP: assert property (go ##2 1'b1 |=>
    (({pin_dir, pin_out} ^ $past({pin_dir, pin_out})) & ~{mq, mq}) == 128'h0)
    else $error("unselected pin changed");
  AST_PORT: assert property (go ##2 1'b1 |=> $stable(bq[5] ? pin_dir[31:0] : pin_dir[63:32]))
    else $error("other port touched");
  AST_REFUSE: assert property (bad ##1 !pw ##1 !pw |=>
    {pin_dir, pin_out} == $past({pin_dir, pin_out}, 3))
    else $error("refused word changed pins");
  AST_NO_RISE: assert property (!$past(pw) |-> (pin_dir & ~$past(pin_dir)) == 64'h0)
    else $error("direction set without register write");
endmodule
bind pin_float_instruction_unit pin_float_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hreadyout, .pin_dir, .pin_out);

/* File: verification/core_issue_model.sv */
`timescale 1ns/1ps
module core_issue_model (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    haddr <= ~{24'h0, a};
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
    hwdata <= ~d;
  endtask
endmodule

/* File: verification/pin_float_instruction_unit_tb.sv */
`timescale 1ns/1ps
module pin_float_instruction_unit_tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, cm, zm;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [10:0] v;
  logic [63:0] pin_dir, pin_out, dm, om;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc = 0;
  always #50 hclk = ~hclk;
  core_issue_model u_core (.hclk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata);
  pin_float_instruction_unit u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .pin_dir, .pin_out);
  task automatic conclude();
    $display("mismatches %0d of %0d checks", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 8000) begin
      n_mismatch++;
      conclude();
    end
  end
  task automatic chk(input string what, input logic [63:0] e, input logic [63:0] s);
    samples_checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_core.xfer(a, 1'b1, d, q);
  endtask
  task automatic rd(input logic [7:0] a);
    u_core.xfer(a, 1'b0, 32'h0, q);
  endtask
  function automatic logic [63:0] msk(logic [5:0] b, logic [4:0] r);
    logic [31:0] m;
    m = 32'hFFFF_FFFF >> (5'h1F - r);
    m = (m << b[4:0]) | (m >> (6'h20 - {1'b0, b[4:0]}));
    return b[5] ? {m, 32'h0} : {32'h0, m};
  endfunction
  task automatic run(input logic [1:0] k, input logic lit, input logic f);
    logic [63:0] m;
    logic lv;
    logic p;
    logic [4:0] r;
    p = 1'($urandom);
    r = 5'($urandom);
    if (lit) wr(8'h0C, {30'h0, v[10:9]});
    else wr(8'h04, {21'h0, v});
    if (!lit && p) begin
      wr(8'h08, {27'h0, r});
      v[10:6] = r;
    end
    wr(8'h00, {4'h0, 7'h6B, f, f, lit, v[8:0], 7'h14, k});
    rd(8'h14);
    chk("early dir", {32'h0, dm[31:0]}, {32'h0, q});
    m = msk(v[5:0], v[10:6]);
    lv = k[1] ? cm ^ k[0] : k[0];
    if (f) {cm, zm} = {2{om[v[5:0]]}};
    om = (om & ~m) | (m & {64{lv}});
    dm = dm & ~m;
    @(posedge hclk);
    chk("dir", dm, pin_dir);
    chk("out", om, pin_out);
    rd(8'h10);
    chk("flags", {62'h0, zm, cm}, {32'h0, q});
  endtask
  task automatic refuse(input logic [31:0] w);
    wr(8'h00, w);
    repeat (4) @(posedge hclk);
    chk("dir kept", dm, pin_dir);
    chk("out kept", om, pin_out);
    rd(8'h24);
    chk("status", 64'h2, {32'h0, q});
    chk("resp", 64'h0, {63'h0, hresp});
  endtask
  initial begin
    void'($urandom(32'hD26E4DE2));
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    dm = {$urandom, $urandom};
    om = {$urandom, $urandom};
    {zm, cm} = 2'($urandom);
    wr(8'h14, dm[31:0]);
    wr(8'h18, dm[63:32]);
    wr(8'h1C, om[31:0]);
    wr(8'h20, om[63:32]);
    wr(8'h10, {30'h0, zm, cm});
    for (int i = 0; i < 40; i++) begin
      v = 11'($urandom);
      if (i == 0) v = 11'h7FF;
      if (i == 1) v = 11'h01F;
      run(i[1:0], i[2], i[3] ^ i[0]);
      $display("test %0d done", i);
    end
    rd(8'h24);
    chk("status legal", 64'h0, {32'h0, q});
    refuse({4'h0, 7'h6B, 3'b101, 9'h0, 9'h052});
    refuse({4'h0, 7'h6B, 3'b001, 9'h0, 9'h054});
    refuse({4'h0, 7'h6A, 3'b001, 9'h0, 9'h050});
    $display("test refusals done");
    conclude();
  end
endmodule
